/* File: common/uar_pkg.sv */
package uar_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ctrl_addr   = 12'h000;
  localparam logic [11:0] status_addr = 12'h004;
  localparam logic [11:0] data_addr   = 12'h008;
  localparam logic [11:0] divisor_addr = 12'h00c;
  localparam logic [11:0] irq_stat_addr = 12'h010;
  localparam logic [11:0] irq_en_addr  = 12'h014;
  localparam logic [11:0] irq_clr_addr = 12'h018;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int ctrl_en_bit    = 0;
  localparam int ctrl_dbl_bit   = 1;
  localparam int ctrl_len_lsb   = 4;
  localparam int ctrl_len_w     = 4;
  localparam logic [3:0] len_reset = 4'h8;
  localparam logic [3:0] len_min   = 4'h5;
  localparam logic [3:0] len_max   = 4'ha;

  // Status fields.
  localparam int stat_done_bit = 0;
  localparam int stat_serr_bit = 1;
  localparam int stat_busy_bit = 2;

  // Interrupt events.
  localparam int irq_rx_bit    = 0;
  localparam int irq_serr_bit  = 1;
  localparam int irq_noise_bit = 2;
  localparam int irq_w         = 3;

  // ----------------------------------------------------------------
  // Sampling figures
  // ----------------------------------------------------------------
  localparam logic [4:0] spb_normal = 5'h10;
  localparam logic [4:0] spb_double = 5'h08;
  localparam logic [4:0] first_normal = 5'h08;
  localparam logic [4:0] first_double = 5'h04;
  localparam logic [15:0] divisor_reset = 16'h0000;
  localparam int depth = 2;

  typedef enum logic [1:0] {
    uar_idle_type  = 2'b00,
    uar_start_type = 2'b01,
    uar_data_type  = 2'b11
  } uar_state_type;

  typedef struct packed {
    logic       serr;
    logic [9:0] data;
  } uar_entry_type;

endpackage

/* File: design/uar_vote.sv */
// ------------------------------------------------------------------
// Three-sample majority vote
// ------------------------------------------------------------------
module uar_vote (
  input  wire logic [2:0] samples,  // Three centre samples
  output logic            level     // Majority level
);

  assign level = (samples[0] & samples[1]) | (samples[0] & samples[2]) |
                 (samples[1] & samples[2]);

endmodule

/* File: design/uar_rx.sv */
// What this block does
// - Clearing the enable aborts any frame in progress at once.
// - While disabled the receiver releases the serial input pin to port use.
// - Disabling empties the receive buffer with its stored stop bit errors; the interrupt status register keeps its bits.
// - The line is sampled 16 times per bit, or 8 times in double speed.
// - Start detection begins on a high to low edge, that first low sample being sample 1.
// - Samples 8-10 (or 4-6) validate the start; two or more high reject it as noise.
// - Sampling is resynchronised to every valid start bit.
// - Recovery steps 16 states per bit, or 8 in double speed.
// - Each data or parity bit is the majority of its three centre samples.
// - Recovery ends with the first stop bit; further stop bits are ignored.
// - The first stop bit is voted and a zero sets the stop bit error flag.
// - A new start edge is accepted right after the last voting sample of the stop bit.
// - The complete flag is one while unread characters remain, zero when empty.
// - The stop bit error travels in the buffer with its character and advances on read.
//
// Added by the designer: the register offsets and the APB slave port.
module uar_rx #(
  parameter int dw = 10  // Widest data plus parity
) (
  input  wire logic        pclk,        // Clock
  input  wire logic        presetn,     // Async reset, low active
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB direction
  input  wire logic [11:0] paddr,       // APB address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  input  wire logic        rxd_pin,     // Serial input pin
  output logic             rx_override, // High while receiver owns the pin
  output logic             irq          // Interrupt level
);

  // ----------------------------------------------------------------
  // Bus decode and control
  // ----------------------------------------------------------------
  logic        acc;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic        receiver_enable_bit_reg;
  logic        double_speed_select_reg;
  logic [3:0]  len_reg;
  logic [15:0] baud_divisor_value_reg;
  logic [15:0] div_cnt_reg;
  logic        tick;

  assign acc     = psel & penable;
  assign wr      = acc & pwrite;
  assign rd      = acc & ~pwrite;
  assign pready  = 1'b1;
  assign mapped  = paddr == uar_pkg::ctrl_addr || paddr == uar_pkg::status_addr ||
                   paddr == uar_pkg::data_addr || paddr == uar_pkg::divisor_addr ||
                   paddr == uar_pkg::irq_stat_addr || paddr == uar_pkg::irq_en_addr ||
                   paddr == uar_pkg::irq_clr_addr;
  assign pslverr = acc & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receiver_enable_bit_reg <= 1'b0;
      double_speed_select_reg <= 1'b0;
      len_reg                 <= uar_pkg::len_reset;
      baud_divisor_value_reg  <= uar_pkg::divisor_reset;
    end else if (wr && paddr == uar_pkg::ctrl_addr) begin
      receiver_enable_bit_reg <= pwdata[uar_pkg::ctrl_en_bit];
      double_speed_select_reg <= pwdata[uar_pkg::ctrl_dbl_bit];
      // Out of range lengths are clamped so the frame always ends.
      if (pwdata[uar_pkg::ctrl_len_lsb +: uar_pkg::ctrl_len_w] < uar_pkg::len_min) begin
        len_reg <= uar_pkg::len_min;
      end else if (pwdata[uar_pkg::ctrl_len_lsb +: uar_pkg::ctrl_len_w] > uar_pkg::len_max) begin
        len_reg <= uar_pkg::len_max;
      end else begin
        len_reg <= pwdata[uar_pkg::ctrl_len_lsb +: uar_pkg::ctrl_len_w];
      end
    end else if (wr && paddr == uar_pkg::divisor_addr) begin
      baud_divisor_value_reg <= pwdata[15:0];
    end
  end

  assign rx_override = receiver_enable_bit_reg;

  // ----------------------------------------------------------------
  // Sample rate divider
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 16'h0000;
    end else if (!receiver_enable_bit_reg || div_cnt_reg >= baud_divisor_value_reg) begin
      div_cnt_reg <= 16'h0000;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  assign tick = receiver_enable_bit_reg && div_cnt_reg >= baud_divisor_value_reg;

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] sync_reg;
  logic       line_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= 3'h7;
      line_reg <= 1'b1;
    end else begin
      sync_reg <= {sync_reg[1:0], rxd_pin};
      if (sync_reg[1] == sync_reg[2]) begin
        line_reg <= sync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock and data recovery
  // ----------------------------------------------------------------
  uar_pkg::uar_state_type state_reg;
  logic [4:0]    samp_reg;
  logic [3:0]    bit_reg;
  logic [2:0]    win_reg;
  logic [dw-1:0] shift_reg;
  logic          prev_reg;
  logic          voted;
  logic [4:0]    spb;
  logic [4:0]    first;
  logic          last_vote;
  logic          frame_done;
  logic          noise;

  assign spb   = double_speed_select_reg ? uar_pkg::spb_double : uar_pkg::spb_normal;
  assign first = double_speed_select_reg ? uar_pkg::first_double : uar_pkg::first_normal;
  uar_vote u_vote (
    .samples ({win_reg[1:0], line_reg}),
    .level   (voted)
  );
  assign last_vote  = tick && samp_reg == first + 5'h02;
  assign frame_done = state_reg == uar_pkg::uar_data_type && last_vote &&
                      bit_reg == len_reg;
  assign noise      = state_reg == uar_pkg::uar_start_type && last_vote && voted;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= uar_pkg::uar_idle_type;
      samp_reg  <= 5'h00;
      bit_reg   <= 4'h0;
      win_reg   <= 3'h7;
      prev_reg  <= 1'b1;
      shift_reg <= '0;
    end else if (!receiver_enable_bit_reg) begin
      state_reg <= uar_pkg::uar_idle_type;
      samp_reg  <= 5'h00;
      bit_reg   <= 4'h0;
      prev_reg  <= 1'b1;
    end else if (tick) begin
      win_reg  <= {win_reg[1:0], line_reg};
      prev_reg <= line_reg;
      unique case (state_reg)
        uar_pkg::uar_idle_type: begin
          if (prev_reg && !line_reg) begin
            state_reg <= uar_pkg::uar_start_type;
            samp_reg  <= 5'h02;
          end
        end
        uar_pkg::uar_start_type: begin
          if (last_vote) begin
            if (voted) begin
              state_reg <= uar_pkg::uar_idle_type;
            end else begin
              state_reg <= uar_pkg::uar_data_type;
              bit_reg   <= 4'h0;
            end
          end
          samp_reg <= (samp_reg == spb) ? 5'h01 : samp_reg + 5'h01;
        end
        uar_pkg::uar_data_type: begin
          samp_reg <= (samp_reg == spb) ? 5'h01 : samp_reg + 5'h01;
          if (last_vote) begin
            if (bit_reg == len_reg) begin
              // early restart
              // The stop sample stays the previous level, so a low stop bit is no start edge.
              state_reg <= uar_pkg::uar_idle_type;
            end else begin
              shift_reg <= {voted, shift_reg[dw-1:1]};
              bit_reg   <= bit_reg + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  uar_pkg::uar_entry_type buf_reg [uar_pkg::depth];
  logic          rp_reg;
  logic          wp_reg;
  logic [1:0]    cnt_reg;
  logic          push;
  logic          pop;
  logic [dw-1:0] aligned;

  // Right-align the bits shifted in at the top.
  assign aligned = shift_reg >> (4'(dw) - len_reg);
  assign push    = frame_done && cnt_reg != 2'(uar_pkg::depth);
  assign pop     = rd && paddr == uar_pkg::data_addr && cnt_reg != 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rp_reg  <= 1'b0;
      wp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (!receiver_enable_bit_reg) begin
      rp_reg  <= 1'b0;
      wp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wp_reg <= ~wp_reg;
      end
      if (pop) begin
        rp_reg <= ~rp_reg;
      end
      cnt_reg <= cnt_reg + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg <= '{default: '0};
    end else if (push) begin
      buf_reg[wp_reg] <= '{serr: ~voted, data: 10'(aligned)};
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [uar_pkg::irq_w-1:0] ist_reg;
  logic [uar_pkg::irq_w-1:0] ien_reg;
  logic [uar_pkg::irq_w-1:0] ev;
  logic [uar_pkg::irq_w-1:0] clr;

  assign ev  = {noise, frame_done & ~voted, push};
  assign clr = (wr && paddr == uar_pkg::irq_clr_addr) ? pwdata[uar_pkg::irq_w-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_reg <= '0;
      ien_reg <= '0;
    end else begin
      ist_reg <= (ist_reg & ~clr) | ev;
      if (wr && paddr == uar_pkg::irq_en_addr) begin
        ien_reg <= pwdata[uar_pkg::irq_w-1:0];
      end
    end
  end

  assign irq = |(ist_reg & ien_reg);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  uar_pkg::uar_entry_type head;

  assign head = buf_reg[rp_reg];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        uar_pkg::ctrl_addr: begin
          prdata[uar_pkg::ctrl_en_bit]  <= receiver_enable_bit_reg;
          prdata[uar_pkg::ctrl_dbl_bit] <= double_speed_select_reg;
          prdata[uar_pkg::ctrl_len_lsb +: uar_pkg::ctrl_len_w] <= len_reg;
        end
        uar_pkg::status_addr: begin
          prdata[uar_pkg::stat_done_bit] <= cnt_reg != 2'h0;
          prdata[uar_pkg::stat_serr_bit] <= cnt_reg != 2'h0 && head.serr;
          prdata[uar_pkg::stat_busy_bit] <= state_reg != uar_pkg::uar_idle_type;
        end
        uar_pkg::data_addr: begin
          prdata[9:0] <= cnt_reg != 2'h0 ? head.data : 10'h000;
        end
        uar_pkg::divisor_addr:  prdata[15:0] <= baud_divisor_value_reg;
        uar_pkg::irq_stat_addr: prdata[uar_pkg::irq_w-1:0] <= ist_reg;
        uar_pkg::irq_en_addr:   prdata[uar_pkg::irq_w-1:0] <= ien_reg;
        default:                prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

/* File: verif/uar_rx_props.sv */
// ----------------------------------------------------------------
// Port checker for the receiver
// ----------------------------------------------------------------
module uar_rx_props (
  input wire logic        pclk,        // Clock
  input wire logic        presetn,     // Async reset, low active
  input wire logic        psel,        // APB select
  input wire logic        penable,     // APB enable
  input wire logic        pwrite,      // APB direction
  input wire logic [11:0] paddr,       // APB address
  input wire logic [31:0] pwdata,      // APB write data
  input wire logic [31:0] prdata,      // APB read data
  input wire logic        pready,      // APB ready
  input wire logic        pslverr,     // APB error
  input wire logic        rxd_pin,     // Serial input pin
  input wire logic        rx_override, // Pin owned
  input wire logic        irq          // Interrupt level
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       en_q;
  logic [2:0] ien_q;
  logic [3:0] quiet;
  logic       acc;
  logic       mapped;
  assign acc    = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= uar_pkg::irq_clr_addr);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q  <= 1'b0;
      ien_q <= 3'h0;
    end else if (acc && pwrite && paddr == uar_pkg::ctrl_addr) begin
      en_q <= pwdata[0];
    end else if (acc && pwrite && paddr == uar_pkg::irq_en_addr) begin
      ien_q <= pwdata[2:0];
    end
  end
  // Counts cycles with the receiver disabled, saturating at 15, so that late pipeline events are over before checks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet <= 4'h0;
    end else if (en_q) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  a_ovr_tracks_en: assert property (
    rx_override == en_q) else $error("override lags enable");
  a_pready_high: assert property (pready) else $error("pready low");
  a_slverr_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no slverr");
  a_slverr_mapped: assert property (acc && mapped |-> !pslverr) else $error("false slverr");
  a_flush_status: assert property (
    acc && !pwrite && paddr == uar_pkg::status_addr && quiet == 4'hf |-> prdata[2:0] == 3'h0)
    else $error("status not flushed");
  a_flush_data: assert property (
    acc && !pwrite && paddr == uar_pkg::data_addr && quiet == 4'hf |-> prdata == 32'h0)
    else $error("data not flushed");
  a_irq_masked: assert property (ien_q == 3'h0 && $past(ien_q) == 3'h0 |-> !irq)
    else $error("irq while masked");
  a_irq_cleared: assert property (
    acc && pwrite && paddr == uar_pkg::irq_clr_addr && pwdata[2:0] == 3'h7 && quiet == 4'hf
    |-> ##2 !irq) else $error("irq not cleared");
endmodule

bind uar_rx uar_rx_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin), .rx_override(rx_override), .irq(irq));

/* File: verif/uar_tx_model.sv */
// ----------------------------------------------------------------
// Remote serial sender
// ----------------------------------------------------------------
module uar_tx_model (
  input  wire logic pclk, // Clock
  output logic      line  // Serial line, idle high
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  task automatic tick(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge pclk);
  endtask
  // exact rate, 5 to 10 bits.
  task automatic send(input logic [9:0] d, input int len, input int spb, input int slow,
                      input logic stop, input int stop_n, input bit gl);
    tick(1'b0, slow);
    if (slow < spb) begin
      tick(1'b1, spb);
      return;
    end
    for (int i = 0; i < len; i++) begin
      if (gl) begin
        tick(d[i], spb / 2);
        tick(!d[i], 1);
        tick(d[i], spb / 2 - 1);
      end else begin
        tick(d[i], spb);
      end
    end
    tick(stop, stop_n);
    if (!stop) begin
      tick(1'b1, spb);
    end
  endtask
endmodule

/* File: verif/uar_rx_tb.sv */
module uar_rx_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rx_override, irq, line;
  logic [9:0]  d;
  int          err_total, n_compared, len, spb;
  uar_rx #(.dw(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd_pin(line), .rx_override(rx_override), .irq(irq));
  uar_tx_model tx (.pclk(pclk), .line(line));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task stop_test;
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task cfg(input logic en, input logic dbl, input int ln);
    apb(1'b1, uar_pkg::ctrl_addr, {24'h0, ln[3:0], 2'h0, dbl, en});
  endtask
  task expect_char(input logic [9:0] v, input int ln, input logic serr);
    logic [9:0] m;
    m = 10'h3ff >> (10 - ln);
    apb(1'b0, uar_pkg::status_addr, 32'h0);
    chk(rd, {30'h0, serr, 1'b1});
    apb(1'b0, uar_pkg::data_addr, 32'h0);
    chk(rd, {22'h0, v & m});
  endtask
  initial begin
    #200000;
    err_total++;
    stop_test;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    err_total = 0;
    n_compared = 0;
    rd = $urandom(32'h83f9);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, uar_pkg::divisor_addr, 32'h0);
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, er}, 32'h1);
    apb(1'b1, uar_pkg::irq_en_addr, 32'h7);
    for (int i = 0; i < 8; i++) begin
      len = 5 + $urandom % 6;
      spb = ($urandom % 2) ? 8 : 16;
      d = 10'($urandom);
      cfg(1'b1, spb == 8, len);
      tx.send(d, len, spb, spb, i % 3 != 0, spb, $urandom % 2);
      repeat (8) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b0, uar_pkg::irq_stat_addr, 32'h0);
      chk(rd, {30'h0, i % 3 == 0, 1'b1});
      expect_char(d, len, i % 3 == 0);
      apb(1'b1, uar_pkg::irq_clr_addr, 32'h7);
    end
    apb(1'b1, uar_pkg::irq_en_addr, 32'h0);
    for (int u = 0; u < 2; u++) begin
      spb = u ? 8 : 16;
      cfg(1'b1, u == 1, 8);
      tx.send(10'h0a5, 8, spb, spb, 1'b1, spb / 2 + 2, 0);
      tx.send(10'h05a, 8, spb, spb, 1'b0, spb, 0);
      tx.send(10'h000, 8, spb, spb / 2, 1'b1, spb, 0);
      repeat (8) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b0, uar_pkg::irq_stat_addr, 32'h0);
      chk(rd, 32'h7);
      expect_char(10'h0a5, 8, 1'b0);
      expect_char(10'h05a, 8, 1'b1);
      apb(1'b0, uar_pkg::status_addr, 32'h0);
      chk(rd & 32'h1, 32'h0);
      apb(1'b1, uar_pkg::irq_clr_addr, 32'h7);
    end
    apb(1'b1, uar_pkg::irq_en_addr, 32'h7);
    // A divisor of one gives a sample tick every second clock, so the divider is used.
    apb(1'b1, uar_pkg::divisor_addr, 32'h1);
    cfg(1'b1, 1'b0, 8);
    tx.send(10'h033, 8, 32, 32, 1'b1, 32, 0);
    tx.send(10'h0cc, 8, 32, 32, 1'b1, 32, 0);
    expect_char(10'h033, 8, 1'b0);
    fork
      tx.send(10'h0f0, 8, 32, 32, 1'b1, 32, 0);
      begin
        repeat (70) @(posedge pclk);
        cfg(1'b0, 1'b0, 8);
        apb(1'b0, uar_pkg::status_addr, 32'h0);
        chk(rd, 32'h0);
      end
    join
    repeat (20) @(posedge pclk);
    chk({31'h0, rx_override}, 32'h0);
    apb(1'b1, uar_pkg::irq_clr_addr, 32'h7);
    apb(1'b0, uar_pkg::status_addr, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, uar_pkg::data_addr, 32'h0);
    chk(rd, 32'h0);
    cfg(1'b1, 1'b0, 8);
    repeat (300) @(posedge pclk);
    apb(1'b0, uar_pkg::status_addr, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, rx_override}, 32'h1);
    stop_test;
  end
endmodule
